//--- rtl/uart_fmt_pkg.sv
// Package of constants and types for the UART format and modem control block
package uart_fmt_pkg;
    // ==========================================
    // Register offsets
    localparam logic [2:0] OFS_LINE_FORMAT = 3'h0;
    localparam logic [2:0] OFS_MODEM_LINE = 3'h1;
    localparam logic [2:0] OFS_INT_ENABLE = 3'h2;
    localparam logic [2:0] OFS_INT_STATUS = 3'h3;
    localparam logic [2:0] OFS_INT_CLEAR = 3'h4;
    // ==========================================
    // Reset values
    localparam logic [7:0] LINE_FORMAT_RST = 8'h00;
    localparam logic [7:0] MODEM_LINE_RST = 8'h00;
    // ==========================================
    // Field positions, line format control
    localparam int LF_PAR_EN = 3;
    localparam int LF_PAR_EVEN = 4;
    localparam int LF_PAR_FORCE = 5;
    localparam int LF_STOP = 2;
    // Field positions, modem line control
    localparam int ML_DTR = 0;
    localparam int ML_RTS = 1;
    localparam int ML_USER_OUTPUT_ONE = 2;
    localparam int ML_USER_OUTPUT_TWO = 3;
    localparam int ML_LOOP = 4;
    localparam int ML_INT_TYPE = 5;
    localparam int ML_IR_EN = 6;
    localparam int ML_CLK_SEL = 7;
    // ==========================================
    // Timing counts
    localparam logic [3:0] PRESCALE_MAX = 4'hf;
    localparam logic [1:0] QUAD_MAX = 2'h3;
    localparam logic [4:0] HALF_STOP_TICKS = 5'h08;
    localparam logic [4:0] ONE_STOP_TICKS = 5'h10;
    localparam logic [4:0] TWO_STOP_TICKS = 5'h10;
    // Status bit positions
    localparam int ST_CTS = 0;
    localparam int ST_DSR = 1;
    localparam int ST_RI = 2;
    localparam int ST_DCD = 3;
    localparam int ST_TX_DONE = 4;
    localparam int ST_RX_DONE = 5;
    // ==========================================
    // Types
    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_ODD = 2'h1,
        PAR_EVEN = 2'h3,
        PAR_FORCED = 2'h2
    } parity_mode_t;

    typedef struct packed {
        logic [3:0] data_bits;
        parity_mode_t par_mode;
        logic par_force_val;
        logic [1:0] stop_halves;
    } frame_fmt_t;

    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic ri_n;
        logic dcd_n;
    } modem_in_t;
endpackage : uart_fmt_pkg

//--- rtl/uart_format_modem_control.sv
// UART character format, prescaler, routing, interrupt pin and loop-back logic
// Overview of operation
// - Parity off, or odd, even, forced one, forced zero from three bits
// - One stop bit; set: one and a half for 5 bits, else two
// - Word length code 00..11 gives five to eight data bits
// - Clock select clear: input clock divided by sixteen feeds baud generator
// - Clock select set: further divide by four
// - Infrared off: serial path uses standard serial pins tx_pin and rx_pin
// - Infrared on: serial path goes through infrared encoder and decoder
// - Infrared on: infrared transmit output low while idle
// - Interrupt type clear: pin actively driven both high and low while output two is set
// - Interrupt type set: open-source wire-OR interrupt pin
// - Loop-back cuts transmit, receive and the four modem inputs from pins
// - Loop-back ties modem data and control signals internally
// - Loop-back keeps receive and transmit interrupts working
// - Loop-back takes modem status sources from lower four control bits
// - Loop-back still gates interrupts through the enable register
// - Loop-back off after reset, on only when its bit is written
// - Output two clear floats interrupt pin; loop-back drives carrier detect directly, not inverted
// - Output one acts only in loop-back, driving ring indicator
`timescale 1ns/10ps
`default_nettype none
module uart_format_modem_control
    import uart_fmt_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic tx_serial,
    input wire logic tx_busy,
    output logic rx_serial,
    output logic baud_tick,
    output frame_fmt_t frame_fmt,
    output logic tx_pin,
    input wire logic rx_pin,
    output logic ir_tx_pin,
    input wire logic ir_rx_pin,
    input wire modem_in_t modem_pins,
    output logic rts_n_pin,
    output logic dtr_n_pin,
    output logic interrupt_pin_o,
    output logic interrupt_pin_oe,
    input wire logic tx_done_evt,
    input wire logic rx_done_evt
);
    // ==========================================
    // Register file
    logic [7:0] line_format_control_reg;
    logic [7:0] modem_line_control_reg;
    logic [5:0] int_enable_reg;
    logic [5:0] int_status_reg;
    logic [5:0] int_status_next;
    logic [5:0] evt_now;
    logic [3:0] modem_now;
    logic [3:0] modem_prev_reg;
    logic loop_on;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
        hit = reg_wr && (a == ofs);
    endfunction : hit

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            line_format_control_reg <= LINE_FORMAT_RST;
            modem_line_control_reg <= MODEM_LINE_RST;
            int_enable_reg <= 6'h00;
        end else begin
            if (hit(reg_addr, OFS_LINE_FORMAT)) begin
                line_format_control_reg <= reg_wdata;
            end
            if (hit(reg_addr, OFS_MODEM_LINE)) begin
                modem_line_control_reg <= reg_wdata;
            end
            if (hit(reg_addr, OFS_INT_ENABLE)) begin
                int_enable_reg <= reg_wdata[5:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OFS_LINE_FORMAT: reg_rdata <= line_format_control_reg;
                OFS_MODEM_LINE: reg_rdata <= modem_line_control_reg;
                OFS_INT_ENABLE: reg_rdata <= {2'h0, int_enable_reg};
                OFS_INT_STATUS: reg_rdata <= {2'h0, int_status_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    assign loop_on = modem_line_control_reg[ML_LOOP];

    // ==========================================
    // Frame format decode
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            frame_fmt <= '0;
        end else begin
            frame_fmt.data_bits <= 4'h5 + {2'h0, line_format_control_reg[1:0]};
            if (!line_format_control_reg[LF_PAR_EN]) begin
                frame_fmt.par_mode <= PAR_NONE;
            end else if (line_format_control_reg[LF_PAR_FORCE]) begin
                frame_fmt.par_mode <= PAR_FORCED;
            end else if (line_format_control_reg[LF_PAR_EVEN]) begin
                frame_fmt.par_mode <= PAR_EVEN;
            end else begin
                frame_fmt.par_mode <= PAR_ODD;
            end
            frame_fmt.par_force_val <= ~line_format_control_reg[LF_PAR_EVEN];
            if (!line_format_control_reg[LF_STOP]) begin
                frame_fmt.stop_halves <= 2'h2;
            end else if (line_format_control_reg[1:0] == 2'h0) begin
                frame_fmt.stop_halves <= 2'h3;
            end else begin
                frame_fmt.stop_halves <= 2'h0;
            end
        end
    end

    // ==========================================
    // Clock prescaler
    logic [3:0] pre_cnt_reg;
    logic [1:0] quad_cnt_reg;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pre_cnt_reg <= 4'h0;
            quad_cnt_reg <= 2'h0;
            baud_tick <= 1'b0;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 4'h1;
            baud_tick <= 1'b0;
            if (pre_cnt_reg == PRESCALE_MAX) begin
                if (!modem_line_control_reg[ML_CLK_SEL]) begin
                    baud_tick <= 1'b1;
                    quad_cnt_reg <= 2'h0;
                end else begin
                    quad_cnt_reg <= quad_cnt_reg + 2'h1;
                    baud_tick <= (quad_cnt_reg == QUAD_MAX);
                end
            end
        end
    end

    // ==========================================
    // Pin input synchronisers
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync3_reg;
    logic [4:0] pin_stable_reg;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sync1_reg <= 5'h1f;
            sync2_reg <= 5'h1f;
            sync3_reg <= 5'h1f;
            pin_stable_reg <= 5'h1f;
        end else begin
            sync1_reg <= {ir_rx_pin, modem_pins};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < 5; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    pin_stable_reg[i] <= sync3_reg[i];
                end
            end
        end
    end
    logic [2:0] rx_sync_reg;
    logic rx_stable_reg;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rx_sync_reg <= 3'h7;
            rx_stable_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
            if (rx_sync_reg[1] == rx_sync_reg[2]) begin
                rx_stable_reg <= rx_sync_reg[2];
            end
        end
    end

    // ==========================================
    // Serial routing and loop-back
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_pin <= 1'b1;
            ir_tx_pin <= 1'b0;
            rx_serial <= 1'b1;
        end else begin
            if (loop_on) begin
                tx_pin <= 1'b1;
                ir_tx_pin <= 1'b0;
                rx_serial <= tx_serial;
            end else if (modem_line_control_reg[ML_IR_EN]) begin
                tx_pin <= 1'b1;
                ir_tx_pin <= tx_busy & ~tx_serial;
                rx_serial <= pin_stable_reg[4];
            end else begin
                tx_pin <= tx_serial;
                ir_tx_pin <= 1'b0;
                rx_serial <= rx_stable_reg;
            end
        end
    end

    // Modem outputs idle inactive during loop-back
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rts_n_pin <= 1'b1;
            dtr_n_pin <= 1'b1;
        end else begin
            rts_n_pin <= loop_on | ~modem_line_control_reg[ML_RTS];
            dtr_n_pin <= loop_on | ~modem_line_control_reg[ML_DTR];
        end
    end

    // Active-high modem status, from pins or looped control bits
    always_comb begin
        if (loop_on) begin
            modem_now[ST_CTS] = modem_line_control_reg[ML_RTS];
            modem_now[ST_DSR] = modem_line_control_reg[ML_DTR];
            modem_now[ST_RI] = modem_line_control_reg[ML_USER_OUTPUT_ONE];
            modem_now[ST_DCD] = modem_line_control_reg[ML_USER_OUTPUT_TWO];
        end else begin
            modem_now[ST_CTS] = ~pin_stable_reg[3];
            modem_now[ST_DSR] = ~pin_stable_reg[2];
            modem_now[ST_RI] = ~pin_stable_reg[1];
            modem_now[ST_DCD] = ~pin_stable_reg[0];
        end
    end

    // ==========================================
    // Interrupt status and pin
    assign evt_now = {rx_done_evt, tx_done_evt, modem_now ^ modem_prev_reg};

    always_comb begin
        int_status_next = int_status_reg;
        if (hit(reg_addr, OFS_INT_CLEAR)) begin
            int_status_next = int_status_next & ~reg_wdata[5:0];
        end
        int_status_next = int_status_next | evt_now;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            modem_prev_reg <= 4'h0;
            int_status_reg <= 6'h00;
        end else begin
            modem_prev_reg <= modem_now;
            int_status_reg <= int_status_next;
        end
    end

    logic irq_level;
    assign irq_level = |(int_status_reg & int_enable_reg);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            interrupt_pin_o <= 1'b0;
            interrupt_pin_oe <= 1'b0;
        end else if (!modem_line_control_reg[ML_USER_OUTPUT_TWO]) begin
            interrupt_pin_o <= 1'b0;
            interrupt_pin_oe <= 1'b0;
        end else if (modem_line_control_reg[ML_INT_TYPE]) begin
            interrupt_pin_o <= 1'b1;
            interrupt_pin_oe <= irq_level;
        end else begin
            interrupt_pin_o <= irq_level;
            interrupt_pin_oe <= 1'b1;
        end
    end

    // ==========================================
    // Assertions
    property p_loop_reset;
        @(posedge core_clk) $rose(rstn) |-> !loop_on;
    endproperty
    a_loop_reset: assert property (p_loop_reset) else $error("loop-back on after reset");

    property p_tick_div16;
        @(posedge core_clk) disable iff (!rstn)
            (baud_tick && !modem_line_control_reg[ML_CLK_SEL])
            |-> ##16 (baud_tick == !$past(modem_line_control_reg[ML_CLK_SEL]));
    endproperty
    a_tick_div16: assert property (p_tick_div16) else $error("tick not every 16");

    property p_tick_div64;
        @(posedge core_clk) disable iff (!rstn)
            (baud_tick && modem_line_control_reg[ML_CLK_SEL]) |-> ##1 !baud_tick [*8];
    endproperty
    a_tick_div64: assert property (p_tick_div64) else $error("tick too soon");

    property p_loop_tx_idle;
        @(posedge core_clk) disable iff (!rstn) loop_on |=> tx_pin;
    endproperty
    a_loop_tx_idle: assert property (p_loop_tx_idle) else $error("tx pin not idle");

    property p_loop_rx;
        @(posedge core_clk) disable iff (!rstn)
            loop_on |=> rx_serial == $past(tx_serial);
    endproperty
    a_loop_rx: assert property (p_loop_rx) else $error("loop data lost");

    property p_ir_idle;
        @(posedge core_clk) disable iff (!rstn) !tx_busy |=> !ir_tx_pin;
    endproperty
    a_ir_idle: assert property (p_ir_idle) else $error("ir tx not low idle");

    property p_int_float;
        @(posedge core_clk) disable iff (!rstn)
            !modem_line_control_reg[ML_USER_OUTPUT_TWO] |=> !interrupt_pin_oe;
    endproperty
    a_int_float: assert property (p_int_float) else $error("int pin driven");

    property p_int_open;
        @(posedge core_clk) disable iff (!rstn)
            (modem_line_control_reg[ML_USER_OUTPUT_TWO] && modem_line_control_reg[ML_INT_TYPE])
            |=> interrupt_pin_o && (interrupt_pin_oe == $past(irq_level));
    endproperty
    a_int_open: assert property (p_int_open) else $error("open source wrong");

    property p_wlen;
        @(posedge core_clk) disable iff (!rstn)
            1'b1 |=> frame_fmt.data_bits == 4'h5 + {2'h0, $past(line_format_control_reg[1:0])};
    endproperty
    a_wlen: assert property (p_wlen) else $error("word length wrong");

    property p_no_par;
        @(posedge core_clk) disable iff (!rstn)
            !line_format_control_reg[LF_PAR_EN] |=> frame_fmt.par_mode == PAR_NONE;
    endproperty
    a_no_par: assert property (p_no_par) else $error("parity not off");

    property p_loop_ri;
        @(posedge core_clk) disable iff (!rstn)
            (loop_on && $past(loop_on) && $rose(modem_line_control_reg[ML_USER_OUTPUT_ONE]))
            |=> int_status_reg[ST_RI];
    endproperty
    a_loop_ri: assert property (p_loop_ri) else $error("ri event lost");

    property p_loop_dcd;
        @(posedge core_clk) disable iff (!rstn)
            (loop_on && $past(loop_on) && $changed(modem_line_control_reg[ML_USER_OUTPUT_TWO]))
            |=> int_status_reg[ST_DCD];
    endproperty
    a_loop_dcd: assert property (p_loop_dcd) else $error("dcd event lost");

    property p_loop_modem;
        @(posedge core_clk) disable iff (!rstn) loop_on |=> rts_n_pin && dtr_n_pin;
    endproperty
    a_loop_modem: assert property (p_loop_modem) else $error("modem out on");

    property p_std_route;
        @(posedge core_clk) disable iff (!rstn)
            (!loop_on && !modem_line_control_reg[ML_IR_EN])
            |=> (tx_pin == $past(tx_serial)) && !ir_tx_pin;
    endproperty
    a_std_route: assert property (p_std_route) else $error("std path wrong");

    property p_ir_route;
        @(posedge core_clk) disable iff (!rstn)
            (!loop_on && modem_line_control_reg[ML_IR_EN]) |=> tx_pin;
    endproperty
    a_ir_route: assert property (p_ir_route) else $error("tx pin not idle in ir");

    property p_stop_two;
        @(posedge core_clk) disable iff (!rstn)
            (line_format_control_reg[LF_STOP] && line_format_control_reg[1:0] != 2'h0)
            |=> frame_fmt.stop_halves == 2'h0;
    endproperty
    a_stop_two: assert property (p_stop_two) else $error("stop length wrong");

    property p_int_active;
        @(posedge core_clk) disable iff (!rstn)
            (modem_line_control_reg[ML_USER_OUTPUT_TWO] && !modem_line_control_reg[ML_INT_TYPE])
            |=> interrupt_pin_oe && (interrupt_pin_o == $past(irq_level));
    endproperty
    a_int_active: assert property (p_int_active) else $error("active int wrong");

    c_loop: cover property (@(posedge core_clk) disable iff (!rstn) $rose(loop_on));
    c_irq: cover property (@(posedge core_clk) disable iff (!rstn) $rose(interrupt_pin_oe));
    c_div4: cover property (@(posedge core_clk) disable iff (!rstn)
        baud_tick && modem_line_control_reg[ML_CLK_SEL]);
endmodule : uart_format_modem_control
`default_nettype wire

//--- sim/modem_peer.sv
// Behavioural far-side peer: modem status lines, serial and infrared receive
`timescale 1ns/10ps
`default_nettype none
module modem_peer
    import uart_fmt_pkg::*;
(
    input wire logic core_clk,
    input wire logic slow,
    input wire logic line_lvl,
    input wire logic ir_lvl,
    input wire modem_in_t mdm_lvl,
    output logic rx_pin,
    output logic ir_rx_pin,
    output modem_in_t modem_pins
);
    // ==========================================
    // Output stage, one cycle behind the request or two when slow
    logic line_d;
    logic ir_d;
    modem_in_t mdm_d;
    initial begin
        rx_pin = 1'b1;
        ir_rx_pin = 1'b1;
        modem_pins = 4'hf;
    end
    always @(posedge core_clk) begin
        line_d <= line_lvl;
        ir_d <= ir_lvl;
        mdm_d <= mdm_lvl;
        rx_pin <= slow ? line_d : line_lvl;
        ir_rx_pin <= slow ? ir_d : ir_lvl;
        modem_pins <= slow ? mdm_d : mdm_lvl;
    end
endmodule : modem_peer
`default_nettype wire

//--- sim/uart_format_modem_control_tb.sv
// Self-checking bench for the format and modem control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, a, b); end end
module uart_format_modem_control_tb
    import uart_fmt_pkg::*;
;
    // ==========================================
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic tx_serial = 1'b1;
    logic tx_busy = 1'b0;
    logic tx_done_evt = 1'b0;
    logic rx_done_evt = 1'b0;
    logic slow = 1'b0;
    logic line_lvl = 1'b1;
    logic ir_lvl = 1'b1;
    modem_in_t mdm_lvl = 4'hf;
    logic [7:0] reg_rdata;
    logic rx_serial;
    logic baud_tick;
    frame_fmt_t frame_fmt;
    logic tx_pin;
    logic ir_tx_pin;
    logic rts_n_pin;
    logic dtr_n_pin;
    logic int_o;
    logic int_oe;
    logic rx_pin;
    logic ir_rx_pin;
    modem_in_t modem_pins;
    int err_total = 0;
    int n_tests = 0;
    int i;
    int c;
    logic [7:0] v;
    parity_mode_t pm;

    always #5 core_clk = ~core_clk;

    uart_format_modem_control u_dut (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_serial(tx_serial),
        .tx_busy(tx_busy), .rx_serial(rx_serial), .baud_tick(baud_tick),
        .frame_fmt(frame_fmt), .tx_pin(tx_pin), .rx_pin(rx_pin), .ir_tx_pin(ir_tx_pin),
        .ir_rx_pin(ir_rx_pin), .modem_pins(modem_pins), .rts_n_pin(rts_n_pin),
        .dtr_n_pin(dtr_n_pin), .interrupt_pin_o(int_o), .interrupt_pin_oe(int_oe),
        .tx_done_evt(tx_done_evt), .rx_done_evt(rx_done_evt)
    );

    modem_peer u_peer (
        .core_clk(core_clk), .slow(slow), .line_lvl(line_lvl), .ir_lvl(ir_lvl),
        .mdm_lvl(mdm_lvl), .rx_pin(rx_pin), .ir_rx_pin(ir_rx_pin), .modem_pins(modem_pins)
    );

    // ==========================================
    // Bus and helper tasks
    task step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rd_chk

    task summarize;
        $display("Checks %0d, errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task gap_chk(input int e);
        int k;
        k = 0;
        while (baud_tick !== 1'b1 && k < 200) begin
            step(1);
            k++;
        end
        step(1);
        c = 1;
        while (baud_tick !== 1'b1 && c < 200) begin
            step(1);
            c++;
        end
        if (k >= 200 || c >= 200) begin
            err_total++;
            summarize();
        end else begin
            `CHK(c, e)
        end
    endtask : gap_chk

    // ==========================================
    // Test sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        step(1);
        `CHK(int_oe, 1'b0)
        `CHK(ir_tx_pin, 1'b0)
        rd_chk(OFS_LINE_FORMAT, LINE_FORMAT_RST);
        rd_chk(OFS_MODEM_LINE, MODEM_LINE_RST);
        rd_chk(3'h5, 8'h00);
        @(posedge core_clk);
        tx_serial <= 1'b0;
        line_lvl <= 1'b0;
        step(8);
        `CHK(tx_pin, 1'b0)
        `CHK(rx_serial, 1'b0)
        gap_chk(16);
        wr(OFS_MODEM_LINE, 8'h80);
        step(2);
        gap_chk(64);
        // Infrared routing with a slow peer
        wr(OFS_MODEM_LINE, 8'h40);
        @(posedge core_clk);
        slow <= 1'b1;
        tx_busy <= 1'b1;
        step(8);
        `CHK(ir_tx_pin, 1'b1)
        `CHK(rx_serial, 1'b1)
        @(posedge core_clk);
        ir_lvl <= 1'b0;
        tx_busy <= 1'b0;
        step(8);
        `CHK(rx_serial, 1'b0)
        `CHK(ir_tx_pin, 1'b0)
        @(posedge core_clk);
        slow <= 1'b0;
        ir_lvl <= 1'b1;
        // Every format code
        for (i = 0; i < 64; i++) begin
            v = 8'(i);
            pm = !v[3] ? PAR_NONE : v[5] ? PAR_FORCED : v[4] ? PAR_EVEN : PAR_ODD;
            wr(OFS_LINE_FORMAT, v);
            step(3);
            `CHK(frame_fmt.data_bits, 4'(5 + i % 4))
            `CHK(frame_fmt.par_mode, pm)
            if (pm == PAR_FORCED) `CHK(frame_fmt.par_force_val, ~v[4])
            `CHK(frame_fmt.stop_halves, !v[2] ? 2'h2 : v[1:0] == 2'h0 ? 2'h3 : 2'h0)
        end
        rd_chk(OFS_LINE_FORMAT, 8'h3f);
        // Modem pin changes outside loop-back
        wr(OFS_MODEM_LINE, 8'h00);
        step(8);
        wr(OFS_INT_CLEAR, 8'h3f);
        @(posedge core_clk);
        mdm_lvl <= 4'h0;
        step(8);
        rd_chk(OFS_INT_STATUS, 8'h0f);
        wr(OFS_INT_CLEAR, 8'h3f);
        @(posedge core_clk);
        mdm_lvl <= 4'h7;
        step(8);
        rd_chk(OFS_INT_STATUS, 8'h0e);
        // Loop-back isolates the pins
        wr(OFS_MODEM_LINE, 8'h10);
        step(8);
        wr(OFS_INT_CLEAR, 8'h3f);
        wr(OFS_INT_STATUS, 8'hff);
        @(posedge core_clk);
        mdm_lvl <= 4'hf;
        line_lvl <= 1'b1;
        tx_serial <= 1'b0;
        step(8);
        rd_chk(OFS_INT_STATUS, 8'h00);
        `CHK(rx_serial, 1'b0)
        `CHK(tx_pin, 1'b1)
        wr(OFS_MODEM_LINE, 8'h1f);
        step(8);
        rd_chk(OFS_INT_STATUS, 8'h0f);
        `CHK(rts_n_pin, 1'b1)
        `CHK(dtr_n_pin, 1'b1)
        @(posedge core_clk);
        tx_done_evt <= 1'b1;
        rx_done_evt <= 1'b1;
        @(posedge core_clk);
        tx_done_evt <= 1'b0;
        rx_done_evt <= 1'b0;
        step(2);
        rd_chk(OFS_INT_STATUS, 8'h3f);
        `CHK(int_oe, 1'b1)
        `CHK(int_o, 1'b0)
        wr(OFS_INT_ENABLE, 8'h20);
        step(3);
        `CHK(int_o, 1'b1)
        wr(OFS_MODEM_LINE, 8'h37);
        step(3);
        `CHK(int_oe, 1'b0)
        wr(OFS_MODEM_LINE, 8'h3f);
        step(3);
        `CHK({int_o, int_oe}, 2'h3)
        wr(OFS_INT_ENABLE, 8'h00);
        step(3);
        `CHK(int_oe, 1'b0)
        wr(OFS_MODEM_LINE, 8'h0b);
        step(8);
        `CHK({rts_n_pin, dtr_n_pin}, 2'h0)
        wr(OFS_INT_CLEAR, 8'h3f);
        wr(OFS_MODEM_LINE, 8'h0f);
        step(8);
        rd_chk(OFS_INT_STATUS, 8'h00);
        summarize();
    end
endmodule : uart_format_modem_control_tb
`default_nettype wire
